//--- hw/pct_top.v
// pad control block for one general-purpose pad
// assumes one ahb-lite master, CLK at 125 MHz, synchronous active-high RST
// sibling pads and the pad data registers live elsewhere
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "pct_defs.vh"
module pct_top (
    input  wire                    CLK,
    input  wire                    RST,
    // ahb-lite slave
    input  wire                    HSEL,
    input  wire [31:0]             HADDR,
    input  wire [1:0]              HTRANS,
    input  wire                    HWRITE,
    input  wire [2:0]              HSIZE,
    input  wire [31:0]             HWDATA,
    input  wire                    HREADY,
    output wire                    HREADYOUT,
    output wire                    HRESP,
    output reg  [31:0]             HRDATA,
    // pad
    input  wire                    PAD_IN,
    output reg                     PAD_OUT,
    output reg                     PAD_OUT_EN_N,
    output wire                    PAD_IN_EN,
    output wire [2:0]              PAD_DRIVE,
    output wire                    PAD_PU_STRONG,
    output wire                    PAD_PD_WEAK,
    output wire                    PAD_PU_MEDIUM,
    output wire                    PAD_HYST,
    output wire                    PAD_ANALOG,
    // digital functions
    input  wire [`PCT_NFUNC-1:0]   FUNC_OUT,
    input  wire [`PCT_NFUNC-1:0]   FUNC_OUT_EN,
    output reg  [`PCT_NFUNC-1:0]   FUNC_IN,
    // interrupts
    output wire                    INTERRUPT_CONTROLLER_REQ,
    output wire                    IRQ
);

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    function fsel_valid;
        input [3:0] code;
        begin
            fsel_valid = (code <= `PCT_FSEL_MAX);
        end
    endfunction

    function trig_valid;
        input [2:0] code;
        begin
            trig_valid = (code <= `PCT_TRIG_LOW);
        end
    endfunction

    // one-hot register select, zero for an unmapped offset
    function [3:0] reg_decode;
        input [`PCT_ADDR_W-1:0] ofs;
        begin
            case (ofs)
                `PCT_OFS_CONTROL:  reg_decode = 4'h1;
                `PCT_OFS_STATUS:   reg_decode = 4'h2;
                `PCT_OFS_MASK:     reg_decode = 4'h4;
                `PCT_OFS_PADSTATE: reg_decode = 4'h8;
                default:           reg_decode = 4'h0;
            endcase
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [31:0]            ctrl_r;
    reg  [31:0]            ctrl_nxt;
    reg                    pending_r;
    reg                    pending_nxt;
    reg  [`PCT_ST_W-1:0]   status_r;
    reg  [`PCT_ST_W-1:0]   status_nxt;
    reg  [`PCT_ST_W-1:0]   mask_r;
    reg                    dp_wr_r;
    reg                    dp_rd_r;
    reg  [`PCT_ADDR_W-1:0] dp_addr_r;
    reg                    dp_hit_r;
    reg  [31:0]            rd_nxt;

    wire                   pad_sync;
    wire                   trig_event;
    wire                   addr_phase;
    wire                   addr_mapped;
    wire [3:0]             fsel;
    wire [2:0]             trig_mode;
    wire                   irq_en;
    wire                   fwd_en;
    wire                   analog;
    wire                   in_en;
    wire                   out_en;
    wire                   wr_ctrl;
    wire                   wr_status;
    wire                   wr_mask;
    wire                   bad_cfg_event;
    wire [31:0]            ctrl_wdata;
    wire [3:0]             ap_sel;
    wire [3:0]             dp_sel;

    // ****************************************************************
    // control field views
    // ****************************************************************
    assign fsel      = ctrl_r[`PCT_B_FSEL_HI:`PCT_B_FSEL_LO];
    assign trig_mode = ctrl_r[`PCT_B_TRIG_HI:`PCT_B_TRIG_LO];
    assign irq_en    = ctrl_r[`PCT_B_IRQEN];
    assign fwd_en    = ctrl_r[`PCT_B_FWD];
    assign analog    = ctrl_r[`PCT_B_ANALOG];
    assign in_en     = ctrl_r[`PCT_B_IE];
    assign out_en    = ctrl_r[`PCT_B_OE];

    // ****************************************************************
    // ahb-lite slave: zero wait states, always OKAY
    // ****************************************************************
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    assign addr_phase  = HSEL & HREADY & HTRANS[1];
    assign ap_sel      = reg_decode(HADDR[`PCT_ADDR_W-1:0]);
    // sub-word accesses are dropped like unmapped ones: each register is
    // one whole word and a partial write would tear a field
    assign addr_mapped = (HADDR[31:`PCT_ADDR_W] == 24'h000000) & (|ap_sel) & (HSIZE == 3'h2);

    // data phase copy of the address phase; a write lands when its data arrives
    always @(posedge CLK) begin
        if (RST) begin
            dp_wr_r   <= 1'b0;
            dp_rd_r   <= 1'b0;
            dp_addr_r <= {`PCT_ADDR_W{1'b0}};
            dp_hit_r  <= 1'b0;
        end else if (HREADY) begin
            dp_wr_r   <= addr_phase & HWRITE;
            dp_rd_r   <= addr_phase & ~HWRITE;
            dp_addr_r <= HADDR[`PCT_ADDR_W-1:0];
            dp_hit_r  <= addr_phase & addr_mapped;
        end
    end

    // unmapped writes are dropped, unmapped reads return zero
    assign dp_sel    = reg_decode(dp_addr_r);
    assign wr_ctrl   = dp_wr_r & dp_hit_r & dp_sel[0];
    assign wr_status = dp_wr_r & dp_hit_r & dp_sel[1];
    assign wr_mask   = dp_wr_r & dp_hit_r & dp_sel[2];

    // read mux settles in the address phase; the flop below holds it for
    // exactly the data phase so a late reader sees zero, not stale data
    always @* begin
        rd_nxt = 32'h00000000;
        case (ap_sel)
            4'h1:    rd_nxt = ctrl_r;
            4'h2:    rd_nxt = {30'h0, status_r};
            4'h4:    rd_nxt = {30'h0, mask_r};
            4'h8:    rd_nxt = {29'h0, INTERRUPT_CONTROLLER_REQ, pending_r, pad_sync};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // read data sampled at the address phase, stands during the data phase
    always @(posedge CLK) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
        end else if (addr_phase & ~HWRITE & addr_mapped) begin
            HRDATA <= rd_nxt;
        end else if (HREADY) begin
            HRDATA <= 32'h00000000;
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // reserved bits never take a write and read as zero
    assign ctrl_wdata = (HWDATA & `PCT_CTRL_WMASK) | (ctrl_r & ~`PCT_CTRL_WMASK);

    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = ctrl_wdata;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            ctrl_r <= `PCT_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // software asking for a reserved function or trigger code is flagged
    assign bad_cfg_event = wr_ctrl &
        (~fsel_valid(ctrl_wdata[`PCT_B_FSEL_HI:`PCT_B_FSEL_LO]) |
         ~trig_valid(ctrl_wdata[`PCT_B_TRIG_HI:`PCT_B_TRIG_LO]));

    // ****************************************************************
    // pad settings
    // ****************************************************************
    // plain register bits; the pad cell decodes the strength steps
    assign PAD_DRIVE     = ctrl_r[`PCT_B_DRV_HI:`PCT_B_DRV_LO];
    assign PAD_PU_STRONG = ctrl_r[`PCT_B_PU_STRONG];
    assign PAD_PD_WEAK   = ctrl_r[`PCT_B_PD_WEAK];
    assign PAD_PU_MEDIUM = ctrl_r[`PCT_B_PU_MED];
    assign PAD_HYST      = ctrl_r[`PCT_B_HYST];
    assign PAD_ANALOG    = analog;
    // receiver stays off in analogue mode to keep the converter input clean
    assign PAD_IN_EN     = in_en & ~analog;

    // ****************************************************************
    // input path
    // ****************************************************************
    // nothing but the synchroniser samples the raw pin
    pct_sync u_sync (
        .CLK (CLK),
        .RST (RST),
        .d   (PAD_IN),
        .q   (pad_sync)
    );

    // each function sees the pad only while it owns it
    genvar gi;
    generate
        for (gi = 0; gi < `PCT_NFUNC; gi = gi + 1) begin : g_func_in
            always @(posedge CLK) begin
                if (RST) begin
                    FUNC_IN[gi] <= 1'b0;
                end else begin
                    FUNC_IN[gi] <= PAD_IN_EN & (fsel == gi) & pad_sync;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // output path
    // ****************************************************************
    // reserved codes and analogue mode leave the driver off
    // registered so the pad sees one clean change per control write
    always @(posedge CLK) begin
        if (RST) begin
            PAD_OUT      <= 1'b0;
            PAD_OUT_EN_N <= 1'b1;
        end else if (~analog & out_en & fsel_valid(fsel)) begin
            PAD_OUT      <= FUNC_OUT[fsel];
            PAD_OUT_EN_N <= ~FUNC_OUT_EN[fsel];
        end else begin
            PAD_OUT      <= 1'b0;
            PAD_OUT_EN_N <= 1'b1;
        end
    end

    // ****************************************************************
    // trigger detection
    // ****************************************************************
    // detection runs only with the receiver on, else a gated low
    // would look like a permanent low-level trigger
    pct_trig u_trig (
        .CLK     (CLK),
        .RST     (RST),
        .arm     (PAD_IN_EN & irq_en),
        .level   (pad_sync),
        .mode    (trig_mode),
        .event_o (trig_event)
    );

    // ****************************************************************
    // pending flag and forwarded request
    // ****************************************************************
    // the pending flag clears by writing one to status bit 0; a level
    // trigger sets it again every cycle while the level holds
    always @* begin
        pending_nxt = pending_r;
        if (wr_status & HWDATA[`PCT_ST_TRIG]) begin
            pending_nxt = 1'b0;
        end
        if (~irq_en) begin
            pending_nxt = 1'b0;
        end else if (trig_event) begin
            pending_nxt = 1'b1;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // a level, so the controller needs no edge capture; it drops as soon
    // as software clears pending or takes away the forward bit
    assign INTERRUPT_CONTROLLER_REQ = pending_r & irq_en & fwd_en;

    // ****************************************************************
    // local interrupt status and mask
    // ****************************************************************
    // status bit 1 flags a reserved code write so a bad setup is visible
    // set wins over a write-one clear in the same cycle
    always @* begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = status_r & ~HWDATA[`PCT_ST_W-1:0];
        end
        if (irq_en & trig_event) begin
            status_nxt[`PCT_ST_TRIG] = 1'b1;
        end
        if (bad_cfg_event) begin
            status_nxt[`PCT_ST_BADCFG] = 1'b1;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            status_r <= `PCT_ST_RESET;
            mask_r   <= `PCT_MASK_RESET;
        end else begin
            status_r <= status_nxt;
            if (wr_mask) begin
                mask_r <= HWDATA[`PCT_ST_W-1:0];
            end
        end
    end

    assign IRQ = |(status_r & mask_r);

endmodule

//--- hw/pct_defs.vh
// register map, field positions and reset values of the pad control block
// assumes a 32-bit ahb-lite slave port with word-aligned registers
`ifndef PCT_DEFS_VH
`define PCT_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define PCT_ADDR_W        8
`define PCT_OFS_CONTROL   8'h64
`define PCT_OFS_STATUS    8'h68
`define PCT_OFS_MASK      8'h6c
`define PCT_OFS_PADSTATE  8'h70

// ****************************************************************
// control register fields
// ****************************************************************
`define PCT_B_FWD         25
`define PCT_B_TRIG_HI     23
`define PCT_B_TRIG_LO     21
`define PCT_B_IRQEN       20
`define PCT_B_DRV_HI      14
`define PCT_B_DRV_LO      12
`define PCT_B_PU_STRONG   11
`define PCT_B_PD_WEAK     9
`define PCT_B_PU_MED      8
`define PCT_B_IE          7
`define PCT_B_OE          6
`define PCT_B_HYST        5
`define PCT_B_ANALOG      4
`define PCT_B_FSEL_HI     3
`define PCT_B_FSEL_LO     0
`define PCT_CTRL_WMASK    32'h02f07bff
`define PCT_CTRL_RESET    32'h00001001

// ****************************************************************
// trigger codes and function select
// ****************************************************************
`define PCT_TRIG_RISE     3'h0
`define PCT_TRIG_FALL     3'h1
`define PCT_TRIG_BOTH     3'h2
`define PCT_TRIG_HIGH     3'h3
`define PCT_TRIG_LOW      3'h4
`define PCT_FSEL_MAX      4'h8
`define PCT_FSEL_GPIO     4'h1
`define PCT_NFUNC         9

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define PCT_ST_W          2
`define PCT_ST_TRIG       0
`define PCT_ST_BADCFG     1
`define PCT_ST_RESET      2'h0
`define PCT_MASK_RESET    2'h0

`endif

//--- hw/pct_sync.v
// two-stage synchroniser for the pad input
// assumes the pad level is asynchronous to CLK
`timescale 1ns/1ps
module pct_sync (
    input  wire CLK,
    input  wire RST,
    input  wire d,
    output wire q
);
    reg meta_r;
    reg sync_r;

    // first stage feeds only the second stage
    always @(posedge CLK) begin
        if (RST) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule

//--- hw/pct_trig.v
// edge and level trigger detector on an already synchronised level
// assumes level and mode are in the CLK domain
`timescale 1ns/1ps
`include "pct_defs.vh"
module pct_trig (
    input  wire       CLK,
    input  wire       RST,
    input  wire       arm,
    input  wire       level,
    input  wire [2:0] mode,
    output reg        event_o
);
    reg prev_r;

    // prev follows the level armed or not, so arming never fakes an edge
    always @(posedge CLK) begin
        if (RST) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level;
        end
    end

    always @* begin
        event_o = 1'b0;
        if (arm) begin
            case (mode)
                `PCT_TRIG_RISE: event_o = level & ~prev_r;
                `PCT_TRIG_FALL: event_o = ~level & prev_r & 1'b1;
                `PCT_TRIG_BOTH: event_o = level ^ prev_r;
                `PCT_TRIG_HIGH: event_o = level;
                `PCT_TRIG_LOW:  event_o = ~level;
                default:        event_o = 1'b0;
            endcase
        end
    end
endmodule

//--- tb/pct_top_properties.sv
// assertions on the pad control block, seen from its top-level ports only
// assumes the control register changes only through the ahb writes seen here
`timescale 1ns/1ps
`include "pct_defs.vh"
module pct_top_props (
    input wire        CLK,
    input wire        RST,
    input wire        HSEL,
    input wire [31:0] HADDR,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire [31:0] HWDATA,
    input wire        HREADY,
    input wire [31:0] HRDATA,
    input wire        PAD_IN,
    input wire        PAD_OUT_EN_N,
    input wire        PAD_IN_EN,
    input wire [2:0]  PAD_DRIVE,
    input wire        PAD_PU_STRONG,
    input wire        PAD_PD_WEAK,
    input wire        PAD_PU_MEDIUM,
    input wire        PAD_HYST,
    input wire        PAD_ANALOG,
    input wire        INTERRUPT_CONTROLLER_REQ
);
    reg        wr_ctl_r;
    reg [31:0] ctl_r;
    wire       take  = HSEL && HREADY && HTRANS[1] && (HADDR == {24'h0, `PCT_OFS_CONTROL});
    wire       armed = ctl_r[`PCT_B_IE] && !ctl_r[`PCT_B_ANALOG];
    wire       fwd   = ctl_r[`PCT_B_FWD] && ctl_r[`PCT_B_IRQEN];

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // ****************************************************************
    // shadow of the control register
    // ****************************************************************
    // reserved bits never stick, so only the writable mask is kept
    always @(posedge CLK) begin
        if (RST) begin
            wr_ctl_r <= 1'b0;
            ctl_r    <= `PCT_CTRL_RESET;
        end else begin
            wr_ctl_r <= take && HWRITE;
            if (wr_ctl_r) begin
                ctl_r <= HWDATA & `PCT_CTRL_WMASK;
            end
        end
    end

    sequence s_read_ctl;
        take && !HWRITE;
    endsequence
    sequence s_pad_edge(logic [2:0] code, logic up);
        armed && ctl_r[25:20] == {2'b10, code, 1'b1} && (up ? $rose(PAD_IN) : $fell(PAD_IN));
    endsequence

    // ****************************************************************
    // properties
    // ****************************************************************
    a_drive_level: assert property (PAD_DRIVE == ctl_r[14:12])
        else $error("drive level differs from control");
    a_pull_enables: assert property ({PAD_PU_STRONG, PAD_PD_WEAK, PAD_PU_MEDIUM} == {ctl_r[11], ctl_r[9], ctl_r[8]})
        else $error("pull enables differ from control");
    a_hyst_follow: assert property (PAD_HYST == ctl_r[5])
        else $error("hysteresis differs from control");
    a_analog_route: assert property (PAD_ANALOG == ctl_r[4])
        else $error("analogue routing differs from control");
    a_input_gate: assert property (PAD_IN_EN == armed)
        else $error("input enable wrong");
    a_output_gate: assert property (!PAD_OUT_EN_N |-> $past(ctl_r[6] && !ctl_r[4]))
        else $error("pad driven with output enable clear");
    a_forward_block: assert property (INTERRUPT_CONTROLLER_REQ |-> fwd)
        else $error("request sent without enable and forward");
    a_read_back: assert property (s_read_ctl |=> HRDATA == $past(ctl_r))
        else $error("control read data wrong");
    a_rise_detect: assert property (s_pad_edge(3'h0, 1'b1) |-> ##[1:6] INTERRUPT_CONTROLLER_REQ)
        else $error("rising edge not forwarded");
    a_fall_detect: assert property (s_pad_edge(3'h1, 1'b0) |-> ##[1:6] INTERRUPT_CONTROLLER_REQ)
        else $error("falling edge not forwarded");
endmodule

bind pct_top pct_top_props u_props (
    .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .PAD_IN(PAD_IN), .PAD_OUT_EN_N(PAD_OUT_EN_N), .PAD_IN_EN(PAD_IN_EN),
    .PAD_DRIVE(PAD_DRIVE), .PAD_PU_STRONG(PAD_PU_STRONG), .PAD_PD_WEAK(PAD_PD_WEAK),
    .PAD_PU_MEDIUM(PAD_PU_MEDIUM), .PAD_HYST(PAD_HYST), .PAD_ANALOG(PAD_ANALOG), .INTERRUPT_CONTROLLER_REQ(INTERRUPT_CONTROLLER_REQ)
);

//--- tb/pct_pad_model.sv
// behavioural pad and the outside source that may drive it
// assumes the bench decides when an outside source drives the pad
`timescale 1ns/1ps
module pct_pad_model (
    input  wire CLK,
    input  wire ext_drive,
    input  wire ext_level,
    input  wire out_en_n,
    input  wire out_data,
    input  wire pull_up,
    input  wire pull_down,
    output wire pad
);
    reg float_r = 1'b0;

    // an undriven, unpulled pad wanders, so nothing may lean on its last value
    always @(posedge CLK) begin
        float_r <= ~float_r;
    end

    assign pad = !out_en_n ? out_data : ext_drive ? ext_level : pull_up ? 1'b1 : pull_down ? 1'b0 : float_r;
endmodule

//--- tb/test_pin_control_with_irq_trigger.sv
// self-checking bench for the pad control block
// assumes pct_top with its bound checker and the pad model beside it
`timescale 1ns/1ps
`include "pct_defs.vh"
module test_pin_control_with_irq_trigger;
    localparam [31:0] A_CTL = 32'h64;
    localparam [31:0] A_ST  = 32'h68;
    localparam [31:0] A_MSK = 32'h6c;
    localparam        LIMIT = 20000;
    reg         clk, rst, hsel, hwrite, ext_drive, ext_level;
    reg  [1:0]  htrans;
    reg  [31:0] haddr, hwdata, v;
    reg  [8:0]  func_out, func_out_en;
    reg  [2:0]  s;
    wire        hready, hresp, pad, pad_out, out_en_n, in_en, pu_s, pd_w, pu_m, hyst, analog, interrupt_controller_req, irq;
    wire [31:0] hrdata;
    wire [2:0]  drive;
    wire [8:0]  func_in;
    integer     mismatches, checked, cycles, k;

    pct_top uut (
        .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .PAD_IN(pad),
        .PAD_OUT(pad_out), .PAD_OUT_EN_N(out_en_n), .PAD_IN_EN(in_en), .PAD_DRIVE(drive), .PAD_PU_STRONG(pu_s),
        .PAD_PD_WEAK(pd_w), .PAD_PU_MEDIUM(pu_m), .PAD_HYST(hyst), .PAD_ANALOG(analog), .FUNC_OUT(func_out),
        .FUNC_OUT_EN(func_out_en), .FUNC_IN(func_in), .INTERRUPT_CONTROLLER_REQ(interrupt_controller_req), .IRQ(irq)
    );
    pct_pad_model u_pad (
        .CLK(clk), .ext_drive(ext_drive), .ext_level(ext_level), .out_en_n(out_en_n), .out_data(pad_out),
        .pull_up(pu_s | pu_m), .pull_down(pd_w), .pad(pad)
    );

    // ****************************************************************
    // bus, compare and closing tasks
    // ****************************************************************
    task bus(input wr, input [31:0] a, input [31:0] wd);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge clk);
            while (!hready) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge clk);
            while (!hready) @(posedge clk);
            v = hrdata;
        end
    endtask
    task wait_n(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input [8*16-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected %0s: expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task test_reset;
        begin
            bus(0, A_CTL, 0);
            chk("control reset", `PCT_CTRL_RESET, v);
            chk("pad reset", 10'h081, {drive, pu_s, pd_w, pu_m, hyst, analog, in_en, out_en_n});
            chk("irq reset", 0, {interrupt_controller_req, irq});
            chk("response", 0, hresp);
            bus(1, 32'h80, 32'hffffffff);
            bus(0, 32'h80, 0);
            chk("unmapped", 0, v);
            bus(1, A_CTL, 32'hfd0f9401);
            bus(0, A_CTL, 0);
            chk("reserved bits", 32'h1001, v);
        end
    endtask
    task test_fields;
        for (k = 0; k < 8; k = k + 1) begin
            s = k;
            bus(1, A_CTL, {17'h0, s, s[0], 1'b0, s[1], s[2], 2'b00, ~s[0], 1'b0, 4'h1});
            wait_n(2);
            chk("pad fields", {s, s[0], s[1], s[2], ~s[0]}, {drive, pu_s, pd_w, pu_m, hyst});
            bus(0, A_CTL, 0);
            chk("fields read", {17'h0, s, s[0], 1'b0, s[1], s[2], 2'b00, ~s[0], 1'b0, 4'h1}, v);
        end
    endtask
    task test_functions;
        begin
            ext_drive <= 1'b0;
            func_out_en <= 9'h1ff;
            for (k = 0; k <= 8; k = k + 1) begin
                func_out <= 9'h1 << k;
                bus(1, A_CTL, 32'hc0 | k);
                wait_n(6);
                chk("function out", 2'b01, {out_en_n, pad_out});
                chk("function in", 9'h1 << k, func_in);
            end
            bus(1, A_CTL, 32'hc9);
            wait_n(6);
            chk("reserved code", 1, out_en_n);
            bus(1, A_CTL, 32'hd1);
            wait_n(6);
            chk("analogue", 12'ha00, {analog, in_en, out_en_n, func_in});
            ext_drive <= 1'b1;
        end
    endtask
    task ev_case(input [31:0] ctl, input idle, input pend, input req);
        reg keep;
        begin
            keep = (ctl[23:21] == `PCT_TRIG_BOTH) || (ctl[23:21] == `PCT_TRIG_HIGH) || (ctl[23:21] == `PCT_TRIG_LOW);
            ext_level <= idle;
            wait_n(4);
            bus(1, A_CTL, ctl);
            bus(1, A_ST, 32'h3);
            bus(1, A_MSK, 32'h0);
            wait_n(6);
            chk("request quiet", 0, interrupt_controller_req);
            ext_level <= ~idle;
            wait_n(6);
            chk("request", req, interrupt_controller_req);
            chk("irq masked", 0, irq);
            bus(0, A_ST, 0);
            chk("pending", pend, v[0]);
            bus(1, A_MSK, 32'h1);
            wait_n(3);
            chk("irq unmasked", pend, irq);
            bus(1, A_ST, 32'h1);
            ext_level <= idle;
            wait_n(6);
            chk("request after", req & keep, interrupt_controller_req);
        end
    endtask
    task test_events;
        begin
            for (k = 0; k < 5; k = k + 1) ev_case(32'h02100080 | (k << 21), (k == 1) || (k == 4), 1, 1);
            ev_case(32'h00100080, 0, 1, 0);
            ev_case(32'h02000080, 0, 0, 0);
            for (k = 5; k < 8; k = k + 1) ev_case(32'h02100080 | (k << 21), 0, 0, 0);
            ev_case(32'h02100090, 0, 0, 0);
            ev_case(32'h02100000, 0, 0, 0);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end
    initial begin
        {mismatches, checked, cycles} = 0;
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 36'h0, 32'h0};
        {func_out, func_out_en, ext_drive, ext_level} = {18'h0, 2'b00};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_reset;
        test_fields;
        test_functions;
        test_events;
        give_verdict;
    end
endmodule
